// ---- hdl/sweep_consts.svh ----
`ifndef SWEEP_CONSTS_SVH
`define SWEEP_CONSTS_SVH

// Control word field positions.
`define CTRL_NO_DWELL_BIT    2
`define CTRL_CONT_CLR_PHASE  10
`define CTRL_CONT_CLR_FREQ   11
`define CTRL_AUTO_CLR_PHASE  13
`define CTRL_AUTO_CLR_FREQ   14
`define CTRL_TIMER_LOAD_UPD  15
`define CTRL_SWEEP_EN_BIT    21

// Widths and layout.
`define CTRL_WIDTH           32
`define FREQ_WIDTH           32
`define INTERVAL_WIDTH       8
`define PHASE_OFS_WIDTH      14
`define PHASE_ACC_WIDTH      32

// Reset values.
`define CTRL_RESET           32'h0000_0000
`define FREQ_RESET           32'h0000_0000
`define INTERVAL_RESET       8'h00
`define PHASE_OFS_RESET      14'h0000

// Timer terminal count.
`define TIMER_TERMINAL       1

// Synchronised pin lanes.
`define PIN_UPDATE           0
`define PIN_DIR              1
`define PIN_PROFILE_ONE      2
`define PIN_COUNT            3

`endif

// ---- hdl/sweep_pkg.sv ----
package sweep_pkg;

	// Sweep sequencer states.
	typedef enum logic [1:0] {
		HOLD_LOW,
		RISE,
		HOLD_HIGH,
		FALL
	} sweep_state_e;

endpackage

// ---- hdl/pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] prev
);

	logic [WIDTH-1:0] meta;

	////////////////////////////////////////////////////////////////////////////
	// Two flops per lane guard against metastability; a third holds the
	// previous settled sample so edges come from two registered samples.
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_lane
			always_ff @(posedge clk) begin
				if (!nrst) begin
					meta[i]  <= 1'b0;
					level[i] <= 1'b0;
					prev[i]  <= 1'b0;
				end else begin
					meta[i]  <= pin[i];
					level[i] <= meta[i];
					prev[i]  <= level[i];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ---- hdl/ramp_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sweep_consts.svh"

module ramp_timer #(
	parameter int WIDTH = `INTERVAL_WIDTH
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             enable,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_value,
	output logic                  tick
);

	logic [WIDTH-1:0] count;
	logic             at_terminal;

	// A loaded value of zero never reaches the terminal count, so the timer
	// stays idle until it is loaded again.
	assign at_terminal = (count == WIDTH'(`TIMER_TERMINAL));
	assign tick        = enable && !load && at_terminal;

	////////////////////////////////////////////////////////////////////////////
	// Down-counter: a forced load wins, terminal count reloads, else count down.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			count <= '0;
		end else if (!enable) begin
			count <= '0;
		end else if (load) begin
			count <= load_value;
		end else if (at_terminal) begin
			count <= load_value;
		end else if (count > WIDTH'(`TIMER_TERMINAL)) begin
			count <= count - WIDTH'(1);
		end
	end

endmodule

`default_nettype wire

// ---- hdl/linear_freq_sweep_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sweep_consts.svh"

// Function
// RQ1: Idle profile zero outputs lower frequency word.
// RQ2: No-dwell: direction rise starts rising sweep.
// RQ3: No-dwell: at top, return to lower, hold.
// RQ4: No-dwell: sweep up only, ignore falls.
// RQ5: Host keeps second profile pin low.
// RQ6: Direction rise: rising step, rising interval load.
// RQ7: Timer counts down to one, steps there.
// RQ8: Rise until upper word, then hold.
// RQ9: Direction fall: negated falling step, falling interval.
// RQ10: Fall until lower word, then hold.
// RQ11: At one, reload interval for current direction.
// RQ12: Any direction change forces timer load.
// RQ13: Update with load bit reloads timer.
// RQ14: Sweep enable rising loads timer by direction.
// RQ15: Auto-clear enables at bits 14, 13.
// RQ16: Continuous-clear enables at bits 11, 10.
// RQ17: Continuous clear holds accumulator at zero.
// RQ18: Auto-clear zeroes on update or profile change.
// RQ19: Clear-and-release repeats until bit cleared.
// RQ20: Frequency and phase clears act independently.
// RQ21: Add 14-bit phase offset after accumulator.
// RQ22: Control bit 21 enables linear sweep.
// RQ23: Only update pin rising edge transfers registers.
// RQ24: Host loads lower and upper words correctly.
// RQ25: Update pin sampled on clock rising edge.
// RQ26: Continuous clear beats auto-clear.
// RQ27: Direction edges from successive registered samples.
module linear_freq_sweep_ctrl (
	input  wire logic                          clk,
	input  wire logic                          nrst,
	input  wire logic                          update_pin,
	input  wire logic                          sweep_direction_pin,
	input  wire logic                          profile_one_pin,
	input  wire logic [`CTRL_WIDTH-1:0]        buf_control_function_reg_one,
	input  wire logic [`FREQ_WIDTH-1:0]        buf_lower_freq_word,
	input  wire logic [`FREQ_WIDTH-1:0]        buf_upper_freq_word,
	input  wire logic [`FREQ_WIDTH-1:0]        buf_rising_freq_step,
	input  wire logic [`FREQ_WIDTH-1:0]        buf_falling_freq_step,
	input  wire logic [`INTERVAL_WIDTH-1:0]    buf_rising_step_interval,
	input  wire logic [`INTERVAL_WIDTH-1:0]    buf_falling_step_interval,
	input  wire logic [`PHASE_OFS_WIDTH-1:0]   buf_phase_offset,
	output logic      [`FREQ_WIDTH-1:0]        freq_word,
	output logic      [`PHASE_OFS_WIDTH-1:0]   phase_word,
	output logic                               sweeping,
	output logic                               sweep_enabled
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations.
	logic [`PIN_COUNT-1:0]        pin_level;
	logic [`PIN_COUNT-1:0]        pin_prev;
	logic                         update_rise;
	logic                         dir;
	logic                         dir_rise;
	logic                         dir_fall;
	logic                         profile_change;
	logic                         clear_event;

	logic [`CTRL_WIDTH-1:0]       control_function_reg_one;
	logic [`FREQ_WIDTH-1:0]       lower_freq_word;
	logic [`FREQ_WIDTH-1:0]       upper_freq_word;
	logic [`FREQ_WIDTH-1:0]       rising_freq_step;
	logic [`FREQ_WIDTH-1:0]       falling_freq_step;
	logic [`INTERVAL_WIDTH-1:0]   rising_step_interval_reg;
	logic [`INTERVAL_WIDTH-1:0]   falling_step_interval_reg;
	logic [`PHASE_OFS_WIDTH-1:0]  phase_offset;

	logic                         sweep_en;
	logic                         sweep_en_q;
	logic                         sweep_en_rise;
	logic                         no_dwell;
	logic                         load_on_update;
	logic                         auto_clr_freq;
	logic                         auto_clr_phase;
	logic                         cont_clr_freq;
	logic                         cont_clr_phase;

	logic                         timer_load;
	logic [`INTERVAL_WIDTH-1:0]   timer_value;
	logic                         step_tick;

	sweep_pkg::sweep_state_e      state;
	logic [`FREQ_WIDTH:0]         rise_sum;
	logic [`FREQ_WIDTH:0]         fall_diff;
	logic                         rise_reached;
	logic                         fall_reached;
	logic                         freq_zero;
	logic                         phase_zero;
	logic [`PHASE_ACC_WIDTH-1:0]  phase_acc;

	// Pick one control bit out of the live control word.
	function automatic logic ctrl_bit(
		input logic [`CTRL_WIDTH-1:0] word,
		input int                     pos
	);
		ctrl_bit = word[pos];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: the pins come from the host's domain.
	// Lanes pack update, direction and profile one, low bit first.
	pin_sync #(
		.WIDTH (`PIN_COUNT)
	) u_pin_sync (
		.clk   (clk),
		.nrst  (nrst),
		.pin   ({profile_one_pin, sweep_direction_pin, update_pin}),
		.level (pin_level),
		.prev  (pin_prev)
	);

	// Edges compare two settled samples, never the first synchroniser flop.
	// A level held under one period may slip past unseen.
	assign update_rise    = pin_level[`PIN_UPDATE] && !pin_prev[`PIN_UPDATE]; // [RQ25]
	assign dir            = pin_level[`PIN_DIR];
	assign dir_rise       = dir && !pin_prev[`PIN_DIR];   // [RQ27]
	assign dir_fall       = !dir && pin_prev[`PIN_DIR];   // [RQ27]
	assign profile_change = (dir != pin_prev[`PIN_DIR]) ||
		(pin_level[`PIN_PROFILE_ONE] != pin_prev[`PIN_PROFILE_ONE]);
	// Either source alone fires the clear-and-release pulse.
	assign clear_event    = update_rise || profile_change;

	////////////////////////////////////////////////////////////////////////////
	// Register transfer from the host's buffers. A direction toggle never
	// causes a transfer; only the update pin edge does.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			control_function_reg_one  <= `CTRL_RESET;
			lower_freq_word           <= `FREQ_RESET;
			upper_freq_word           <= `FREQ_RESET;
			rising_freq_step          <= `FREQ_RESET;
			falling_freq_step         <= `FREQ_RESET;
			rising_step_interval_reg  <= `INTERVAL_RESET;
			falling_step_interval_reg <= `INTERVAL_RESET;
			phase_offset              <= `PHASE_OFS_RESET;
		end else if (update_rise) begin // [RQ23]
			control_function_reg_one  <= buf_control_function_reg_one;
			lower_freq_word           <= buf_lower_freq_word;
			upper_freq_word           <= buf_upper_freq_word;
			rising_freq_step          <= buf_rising_freq_step;
			falling_freq_step         <= buf_falling_freq_step;
			rising_step_interval_reg  <= buf_rising_step_interval;
			falling_step_interval_reg <= buf_falling_step_interval;
			phase_offset              <= buf_phase_offset;
		end
	end

	// Control fields decoded from the active control word.
	// The old word decides clear and timer reload on its own
	// transfer edge; the new bits apply from the next cycle.
	assign sweep_en       = ctrl_bit(control_function_reg_one, `CTRL_SWEEP_EN_BIT);   // [RQ22]
	assign no_dwell       = ctrl_bit(control_function_reg_one, `CTRL_NO_DWELL_BIT);
	assign load_on_update = ctrl_bit(control_function_reg_one, `CTRL_TIMER_LOAD_UPD);
	assign auto_clr_freq  = ctrl_bit(control_function_reg_one, `CTRL_AUTO_CLR_FREQ);  // [RQ15]
	assign auto_clr_phase = ctrl_bit(control_function_reg_one, `CTRL_AUTO_CLR_PHASE); // [RQ15]
	assign cont_clr_freq  = ctrl_bit(control_function_reg_one, `CTRL_CONT_CLR_FREQ);  // [RQ16]
	assign cont_clr_phase = ctrl_bit(control_function_reg_one, `CTRL_CONT_CLR_PHASE); // [RQ16]

	////////////////////////////////////////////////////////////////////////////
	// Sweep enable edge tracking.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sweep_en_q <= 1'b0;
		end else begin
			sweep_en_q <= sweep_en;
		end
	end

	assign sweep_en_rise = sweep_en && !sweep_en_q;

	////////////////////////////////////////////////////////////////////////////
	// Ramp timer. After an edge the pin level already equals the new
	// direction, so one level-based choice covers every load source. The
	// interval used is the one in force; a value arriving with the same
	// update edge applies from the next load.
	// A zero interval leaves the timer idle, so no step is taken.
	assign timer_value = dir ? rising_step_interval_reg     // [RQ6] [RQ11]
	                         : falling_step_interval_reg;   // [RQ9] [RQ11]
	assign timer_load  = sweep_en_rise ||                   // [RQ14]
		(sweep_en && (dir_rise || dir_fall)) ||              // [RQ12]
		(sweep_en && load_on_update && update_rise);         // [RQ13]

	ramp_timer #(
		.WIDTH (`INTERVAL_WIDTH)
	) u_ramp_timer (
		.clk        (clk),
		.nrst       (nrst),
		.enable     (sweep_en),
		.load       (timer_load),
		.load_value (timer_value),
		.tick       (step_tick) // [RQ7]
	);

	////////////////////////////////////////////////////////////////////////////
	// Step arithmetic with a spare bit. A step that would pass the terminal
	// word is clamped to it (a no-dwell rise drops to the lower word instead),
	// so a step that does not divide the span evenly still ends exactly on the terminal frequency.
	// The spare bit catches a wrap past the top of the range.
	assign rise_sum     = {1'b0, freq_word} + {1'b0, rising_freq_step};
	assign fall_diff    = {1'b0, freq_word} - {1'b0, falling_freq_step};
	assign rise_reached = rise_sum >= {1'b0, upper_freq_word};             // [RQ8]
	assign fall_reached = fall_diff[`FREQ_WIDTH] ||
		(fall_diff[`FREQ_WIDTH-1:0] <= lower_freq_word);                   // [RQ10]

	// Continuous clear outranks the clear-and-release pulse.
	assign freq_zero  = cont_clr_freq ||                                    // [RQ17] [RQ26]
		(auto_clr_freq && clear_event);                                     // [RQ18] [RQ19]
	assign phase_zero = cont_clr_phase ||                                   // [RQ17] [RQ26] [RQ20]
		(auto_clr_phase && clear_event);                                    // [RQ18] [RQ19] [RQ20]

	////////////////////////////////////////////////////////////////////////////
	// Sweep sequencer state.
	// No-dwell ignores falling edges and drops from the top
	// straight to hold-low. Disabling the sweep or a continuous frequency
	// clear parks it in hold-low as well, so that no stale ramp
	// resumes once the cause has gone.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= sweep_pkg::HOLD_LOW;
		end else if (!sweep_en || cont_clr_freq) begin
			state <= sweep_pkg::HOLD_LOW;
		end else if (sweep_en_rise) begin
			state <= dir ? sweep_pkg::RISE : sweep_pkg::HOLD_LOW;
		end else if (dir_rise) begin
			state <= sweep_pkg::RISE;                                   // [RQ2] [RQ6]
		end else if (dir_fall && !no_dwell) begin
			state <= sweep_pkg::FALL;                                   // [RQ9] [RQ4]
		end else if (step_tick) begin
			case (state)
				sweep_pkg::RISE: begin
					if (rise_reached) begin
						state <= no_dwell ? sweep_pkg::HOLD_LOW     // [RQ3]
						                  : sweep_pkg::HOLD_HIGH;   // [RQ8]
					end
				end
				sweep_pkg::FALL: begin
					if (fall_reached) begin
						state <= sweep_pkg::HOLD_LOW;               // [RQ10]
					end
				end
				sweep_pkg::HOLD_LOW: begin
					state <= sweep_pkg::HOLD_LOW;
				end
				sweep_pkg::HOLD_HIGH: begin
					state <= sweep_pkg::HOLD_HIGH;
				end
				default: begin
					state <= sweep_pkg::HOLD_LOW;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frequency accumulator. Outside sweep the lower word is the tone; a
	// clear forces zero for as long as it lasts; after an auto-clear pulse a
	// rising ramp steps on from zero and a falling one drops to the lower word at its next step, but a continuous clear parks it in hold-low.
	// The clear is tested first so that it beats every source.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			freq_word <= `FREQ_RESET;
		end else if (freq_zero) begin
			freq_word <= `FREQ_RESET;                                   // [RQ17] [RQ18]
		end else if (!sweep_en) begin
			freq_word <= lower_freq_word;                               // [RQ1]
		end else if (sweep_en_rise) begin
			freq_word <= lower_freq_word;
		end else if (step_tick) begin
			case (state)
				sweep_pkg::RISE: begin
					if (rise_reached) begin
						freq_word <= no_dwell ? lower_freq_word     // [RQ3]
						                      : upper_freq_word;    // [RQ8]
					end else begin
						freq_word <= rise_sum[`FREQ_WIDTH-1:0];     // [RQ6]
					end
				end
				sweep_pkg::FALL: begin
					if (fall_reached) begin
						freq_word <= lower_freq_word;               // [RQ10]
					end else begin
						freq_word <= fall_diff[`FREQ_WIDTH-1:0];    // [RQ9]
					end
				end
				sweep_pkg::HOLD_LOW: begin
					freq_word <= freq_word;
				end
				sweep_pkg::HOLD_HIGH: begin
					freq_word <= freq_word;
				end
				default: begin
					freq_word <= freq_word;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Phase accumulator runs on the frequency word, independent of the
	// frequency clear apart from the word it adds.
	// Only the top bits reach the output; the rest is resolution.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			phase_acc <= '0;
		end else if (phase_zero) begin
			phase_acc <= '0;                                            // [RQ20]
		end else begin
			phase_acc <= phase_acc + freq_word;
		end
	end

	// Offset is added to the accumulator's top bits; the sum wraps, as a
	// phase should.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			phase_word <= `PHASE_OFS_RESET;
		end else begin
			phase_word <= phase_acc[`PHASE_ACC_WIDTH-1 -: `PHASE_OFS_WIDTH] +
				phase_offset;                                           // [RQ21]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status flops.
	// Both flags lag one cycle, the price of outputs taken from flops.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sweeping      <= 1'b0;
			sweep_enabled <= 1'b0;
		end else begin
			sweeping      <= (state == sweep_pkg::RISE) || (state == sweep_pkg::FALL);
			sweep_enabled <= sweep_en;
		end
	end

endmodule

`default_nettype wire

// ---- tb/host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// Host side of the pins: update strobe and both profile lines, moved 10 ns after an edge.
module host_model (
	input  wire logic clk,
	output logic      update_pin,
	output logic      sweep_direction_pin,
	output logic      profile_one_pin
);
	initial begin
		update_pin = 1'h0;
		sweep_direction_pin = 1'h0;
		profile_one_pin = 1'h0;
	end

	////////////////////////////////////////
	// Three cycles high and three low, so the two-stage sync never misses a pulse.
	task automatic upd();
		@(posedge clk) #10 update_pin = 1'h1;
		repeat (2) @(posedge clk);
		@(posedge clk) #10 update_pin = 1'h0;
		repeat (3) @(posedge clk);
		#10;
	endtask

	// The direction line is the first profile input.
	task automatic dir(input logic v);
		@(posedge clk) #10 sweep_direction_pin = v;
		repeat (3) @(posedge clk);
		#10;
	endtask

	// The second profile line may only move while no sweep is active.
	task automatic prof(input logic sweep_on);
		@(posedge clk) #10 profile_one_pin = sweep_on ? 1'h0 : !profile_one_pin;
		repeat (3) @(posedge clk);
		#10;
	endtask
endmodule

`default_nettype wire

// ---- tb/sweep_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none

// Port watcher; it keeps its own copy of the buffers in force after each transfer.
module sweep_asserts (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        update_pin,
	input wire logic        sweep_direction_pin,
	input wire logic        profile_one_pin,
	input wire logic [31:0] buf_control_function_reg_one,
	input wire logic [31:0] buf_lower_freq_word,
	input wire logic [31:0] buf_upper_freq_word,
	input wire logic [7:0]  buf_rising_step_interval,
	input wire logic [7:0]  buf_falling_step_interval,
	input wire logic [13:0] buf_phase_offset,
	input wire logic [31:0] freq_word,
	input wire logic [13:0] phase_word,
	input wire logic        sweeping,
	input wire logic        sweep_enabled
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);

	logic [2:0]  us;
	logic [2:0]  ds;
	logic [31:0] ctrl;
	logic [31:0] lo;
	logic [31:0] hi;
	logic [7:0]  ri;
	logic [7:0]  fi;
	logic [13:0] ofs;
	logic [2:0]  age;
	logic        urise;
	logic        calm;

	////////////////////////////////////////
	// Same sync depth as the block, so our transfer edge lines up with its own.
	assign urise = us[1] && !us[2];
	assign calm = age > 3'h2 && !ctrl[11] && !ctrl[14];
	always_ff @(posedge clk) begin
		if (!nrst) begin
			us <= 3'h0;
			ds <= 3'h0;
		end else begin
			us <= {us[1:0], update_pin};
			ds <= {ds[1:0], sweep_direction_pin};
		end
	end

	// Age saturates, and outputs are judged only once a transfer has settled, except by chk_auto_pulse.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl <= 32'h0000_0000;
			lo <= 32'h0000_0000;
			hi <= 32'h0000_0000;
			ri <= 8'h00;
			fi <= 8'h00;
			ofs <= 14'h0000;
			age <= 3'h7;
		end else if (urise) begin
			ctrl <= buf_control_function_reg_one;
			lo <= buf_lower_freq_word;
			hi <= buf_upper_freq_word;
			ri <= buf_rising_step_interval;
			fi <= buf_falling_step_interval;
			ofs <= buf_phase_offset;
			age <= 3'h0;
		end else if (age != 3'h7) begin
			age <= age + 3'h1;
		end
	end

	////////////////////////////////////////
	chk_enable_bit: assert property (age > 3'h2 |-> sweep_enabled == ctrl[21])
		else $error("sweep enable flag wrong");
	chk_cont_freq: assert property (age > 3'h2 && ctrl[11] |-> freq_word == 32'h0000_0000)
		else $error("frequency not held at zero");
	chk_cont_phase: assert property (age > 3'h3 && ctrl[10] |-> phase_word == ofs)
		else $error("phase word not equal to offset");
	chk_single_tone: assert property (calm && !ctrl[21] && !sweep_direction_pin && !profile_one_pin
		|-> freq_word == lo) else $error("lower word not in force");
	chk_sweep_range: assert property (calm && ctrl[21] |-> freq_word >= lo && freq_word <= hi)
		else $error("frequency outside the sweep span");
	chk_step_gap: assert property (calm && ctrl[21] && !ctrl[2] && ri > 8'h01 && fi > 8'h01
		&& sweeping && $changed(freq_word) |=> $stable(freq_word)) else $error("steps too close");
	chk_no_dwell_up: assert property (calm && ctrl[21] && ctrl[2]
		|-> freq_word >= $past(freq_word) || freq_word == lo) else $error("no-dwell sweep went down");
	chk_dwell_hold: assert property (calm && ctrl[21] && !ctrl[2] && &ds && freq_word == hi
		|=> freq_word == hi) else $error("upper word not held");
	chk_auto_pulse: assert property (urise && ctrl[14] && buf_control_function_reg_one[14] && !ctrl[11]
		&& !buf_control_function_reg_one[11] |-> ##[1:3] freq_word == 32'h0000_0000) else $error("no auto clear");
endmodule

bind linear_freq_sweep_ctrl sweep_asserts i_sweep_asserts (
	.clk, .nrst, .update_pin, .sweep_direction_pin, .profile_one_pin,
	.buf_control_function_reg_one, .buf_lower_freq_word, .buf_upper_freq_word,
	.buf_rising_step_interval, .buf_falling_step_interval, .buf_phase_offset,
	.freq_word, .phase_word, .sweeping, .sweep_enabled
);

`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb;
	typedef struct {
		logic [31:0] c;
		logic [31:0] lo;
		logic [13:0] ofs;
		logic [31:0] f;
		logic        en;
	} row_s;

	logic        clk = 1'h0;
	logic        nrst = 1'h0;
	wire logic   update_pin;
	wire logic   sweep_direction_pin;
	wire logic   profile_one_pin;
	logic [31:0] buf_control_function_reg_one = 32'h0000_0000;
	logic [31:0] buf_lower_freq_word = 32'h0000_0100;
	logic [31:0] buf_upper_freq_word = 32'h0000_0130;
	logic [31:0] buf_rising_freq_step = 32'h0000_0010;
	logic [31:0] buf_falling_freq_step = 32'h0000_0008;
	logic [7:0]  buf_rising_step_interval = 8'h04;
	logic [7:0]  buf_falling_step_interval = 8'h03;
	logic [13:0] buf_phase_offset = 14'h0000;
	logic [31:0] freq_word;
	logic [13:0] phase_word;
	logic        sweeping;
	logic        sweep_enabled;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          n;
	// Control word, lower word, offset, then expected frequency and enable flag.
	row_s        rows [5] = '{
		'{32'h0000_0400, 32'h1234_5678, 14'h1555, 32'h1234_5678, 1'h0},
		'{32'h0000_0c00, 32'h0000_0100, 14'h2aaa, 32'h0000_0000, 1'h0},
		'{32'h0020_0400, 32'h0000_0100, 14'h0001, 32'h0000_0100, 1'h1},
		'{32'h0020_4c00, 32'h0000_0100, 14'h3fff, 32'h0000_0000, 1'h1},
		'{32'h0000_0400, 32'h0000_0100, 14'h0000, 32'h0000_0100, 1'h0}
	};

	always #50 clk = ~clk;

	linear_freq_sweep_ctrl i_linear_freq_sweep_ctrl (
		.clk, .nrst, .update_pin, .sweep_direction_pin, .profile_one_pin,
		.buf_control_function_reg_one, .buf_lower_freq_word, .buf_upper_freq_word,
		.buf_rising_freq_step, .buf_falling_freq_step, .buf_rising_step_interval,
		.buf_falling_step_interval, .buf_phase_offset,
		.freq_word, .phase_word, .sweeping, .sweep_enabled
	);
	host_model i_host_model (.clk, .update_pin, .sweep_direction_pin, .profile_one_pin);

	////////////////////////////////////////
	task automatic finish_test();
		$display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_flag(input logic got, input logic exp);
		cmp_word({31'h0, got}, {31'h0, exp});
	endtask

	// Bounded wait for a frequency; k returns the edges it took.
	task automatic wait_freq(input logic [31:0] v, output int k);
		k = 0;
		while (freq_word !== v && k < 60) begin
			@(posedge clk);
			#10 k++;
		end
		cmp_word(freq_word, v);
	endtask

	task automatic load(input logic [31:0] c);
		buf_control_function_reg_one = c;
		i_host_model.upd();
		repeat (2) @(posedge clk);
		#10;
	endtask

	// Catches the one-cycle zero of an auto clear, then the lower word back.
	task automatic pulse_check();
		int k;
		wait_freq(32'h0000_0000, k);
		@(posedge clk);
		#10 cmp_word(freq_word, 32'h0000_0100);
	endtask

	////////////////////////////////////////
	initial begin
		#(100 * 5000);
		n_mismatch++;
		finish_test();
	end

	initial begin
		repeat (5) @(posedge clk);
		#10 cmp_word(freq_word | {18'h0, phase_word}, 32'h0000_0000);
		cmp_flag(sweeping | sweep_enabled, 1'h0);
		nrst = 1'h1;
		foreach (rows[i]) begin
			buf_lower_freq_word = rows[i].lo;
			buf_phase_offset = rows[i].ofs;
			load(rows[i].c);
			cmp_word(freq_word, rows[i].f);
			cmp_word({18'h0, phase_word}, {18'h0, rows[i].ofs});
			cmp_flag(sweep_enabled, rows[i].en);
		end
		// Dwell sweep; the lower buffer is spoiled without a transfer to prove it is ignored.
		load(32'h0020_0000);
		cmp_word(freq_word, 32'h0000_0100);
		buf_lower_freq_word = 32'h0000_0050;
		i_host_model.dir(1'h1);
		wait_freq(32'h0000_0110, n);
		cmp_flag(sweeping, 1'h1);
		wait_freq(32'h0000_0120, n);
		cmp_word(n, 4);
		wait_freq(32'h0000_0130, n);
		repeat (10) @(posedge clk);
		#10 cmp_word(freq_word, 32'h0000_0130);
		cmp_flag(sweeping, 1'h0);
		i_host_model.dir(1'h0);
		wait_freq(32'h0000_0128, n);
		wait_freq(32'h0000_0120, n);
		cmp_word(n, 3);
		wait_freq(32'h0000_0100, n);
		// No-dwell: up once per rising edge, straight back, falls ignored.
		buf_lower_freq_word = 32'h0000_0100;
		load(32'h0020_0004);
		i_host_model.dir(1'h1);
		wait_freq(32'h0000_0120, n);
		wait_freq(32'h0000_0100, n);
		cmp_flag(n < 6, 1'h1);
		repeat (20) @(posedge clk);
		#10 cmp_word(freq_word, 32'h0000_0100);
		i_host_model.dir(1'h0);
		repeat (20) @(posedge clk);
		#10 cmp_word(freq_word, 32'h0000_0100);
		cmp_flag(sweeping, 1'h0);
		i_host_model.dir(1'h1);
		wait_freq(32'h0000_0110, n);
		// Enabling with the direction high starts a rising sweep at once.
		load(32'h0000_0000);
		load(32'h0020_0000);
		wait_freq(32'h0000_0130, n);
		i_host_model.dir(1'h0);
		wait_freq(32'h0000_0100, n);
		// Update reload with fresh intervals and a higher top word.
		buf_upper_freq_word = 32'h0000_0140;
		buf_rising_step_interval = 8'h06;
		buf_falling_step_interval = 8'h05;
		load(32'h0020_8000);
		i_host_model.dir(1'h1);
		wait_freq(32'h0000_0110, n);
		load(32'h0020_8000);
		cmp_word(freq_word, 32'h0000_0110);
		wait_freq(32'h0000_0120, n);
		cmp_word(n, 1);
		wait_freq(32'h0000_0130, n);
		cmp_word(n, 6);
		wait_freq(32'h0000_0140, n);
		i_host_model.dir(1'h0);
		wait_freq(32'h0000_0138, n);
		wait_freq(32'h0000_0130, n);
		cmp_word(n, 5);
		// Auto clear on a transfer and again on a profile change.
		load(32'h0000_4000);
		fork
			load(32'h0000_4000);
			pulse_check();
		join
		fork
			i_host_model.prof(1'h0);
			pulse_check();
		join
		// A reset in mid-run zeroes every output; no transfer follows it.
		nrst = 1'h0;
		repeat (2) @(posedge clk);
		#10 cmp_word(freq_word | {18'h0, phase_word}, 32'h0000_0000);
		cmp_flag(sweeping | sweep_enabled, 1'h0);
		nrst = 1'h1;
		repeat (4) @(posedge clk);
		#10 cmp_word(freq_word, 32'h0000_0000);
		finish_test();
	end
endmodule

`default_nettype wire
